// file: hdl/ctp_consts.svh
// Purpose: Offsets, field positions, reset values for the priority/stamp block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef CTP_CONSTS_SVH
`define CTP_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CTP_OFF_CTRL 8'h00
`define CTP_OFF_TX_FLAG 8'h04
`define CTP_OFF_TX_SEL 8'h08
`define CTP_OFF_TX_PRIO 8'h0c
`define CTP_OFF_TX_STAMP_HI 8'h10
`define CTP_OFF_TX_STAMP_LO 8'h14
`define CTP_OFF_RX_STAMP_HI 8'h18
`define CTP_OFF_RX_STAMP_LO 8'h1c
`define CTP_OFF_RX_FLAG 8'h20
`define CTP_OFF_IRQ_STAT 8'h24
`define CTP_OFF_IRQ_MASK 8'h28

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define CTP_CTRL_STAMP_EN 0
`define CTP_CTRL_INIT 1
`define CTP_CTRL_RST 2'h2
`define CTP_EV_TX_DONE 0
`define CTP_EV_RX_FULL 1
`define CTP_EV_RST 2'h0
`define CTP_PRIO_RST 8'h00
`define CTP_STAMP_RST 16'h0000

`endif

// file: hdl/ctp_pkg.sv
// Purpose: Types shared by the priority/stamp block
// Assumes: Nothing beyond the constants header
// Notes: Register selector used by the APB decode
package ctp_pkg;

    typedef logic [7:0] ctp_prio_t;
    typedef logic [15:0] ctp_stamp_t;

    typedef enum {
        CTP_REG_CTRL,
        CTP_REG_TX_FLAG,
        CTP_REG_TX_SEL,
        CTP_REG_TX_PRIO,
        CTP_REG_TX_STAMP_HI,
        CTP_REG_TX_STAMP_LO,
        CTP_REG_RX_STAMP_HI,
        CTP_REG_RX_STAMP_LO,
        CTP_REG_RX_FLAG,
        CTP_REG_IRQ_STAT,
        CTP_REG_IRQ_MASK,
        CTP_REG_NONE
    } ctp_reg_t;

endpackage

// file: hdl/ctp_stamp_counter.sv
// Purpose: Free-running 16-bit stamp timer on the bit clock
// Assumes: tick_i is a one-cycle strobe per bit time, same clock
// Notes: Wraps silently; held at zero while clear_i is high
`timescale 1ns/100ps
`default_nettype none
`include "ctp_consts.svh"
module ctp_stamp_counter
    import ctp_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic clear_i,
    output logic [15:0] count_o
);
    logic [15:0] next_count;

    always_comb
    begin
        next_count = count_o;
        if (clear_i)
        begin
            next_count = `CTP_STAMP_RST; // R7
        end
        else if (tick_i)
        begin
            // No overrun flag exists on purpose
            next_count = count_o + 16'h0001; // R5 R6
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            count_o <= `CTP_STAMP_RST;
        end
        else
        begin
            count_o <= next_count;
        end
    end
endmodule
`default_nettype wire

// file: hdl/ctp_prio_arbiter.sv
// Purpose: Pick the pending transmit buffer with the lowest priority value
// Assumes: Priorities packed 8 bits per buffer, buffer 0 lowest bits
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/100ps
`default_nettype none
module ctp_prio_arbiter
    import ctp_pkg::*;
#(
    parameter int BUFS = 3,
    parameter int IDX_W = 2
)
(
    input wire logic [BUFS-1:0] request_i,
    input wire logic [BUFS*8-1:0] prio_i,
    output logic win_valid_o,
    output logic [IDX_W-1:0] win_idx_o
);
    ctp_prio_t best;

    always_comb
    begin
        win_valid_o = 1'b0;
        win_idx_o = '0;
        best = 8'hff;
        for (int i = 0; i < BUFS; i++)
        begin
            // Strictly less: an equal value never displaces a lower index
            if (request_i[i] && (!win_valid_o || prio_i[i*8 +: 8] < best))
            begin
                win_valid_o = 1'b1; // R1
                win_idx_o = IDX_W'(i);
                best = prio_i[i*8 +: 8];
            end
        end
    end
endmodule
`default_nettype wire

// file: hdl/ctp_tx_prio_stamp.sv
// Purpose: Transmit buffer priority choice and message time stamping
// Assumes: APB slave; frame events come from the protocol engine, same clock
// Notes: No wait state on any APB access; gated accesses give pslverr
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "ctp_consts.svh"

// Summary of operation
// R1: Among equal lowest priorities the lower-numbered buffer is sent first.
// R2: A priority register is reachable only while its buffer is empty and selected.
// R3: With stamping enabled the timer is stored in the active buffer after each valid end of frame.
// R4: Software reads a transmit stamp only once that buffer is flagged empty again.
// R5: The stamp timer runs freely, advancing on each bit-clock tick.
// R6: The stamp timer wraps with no overrun indication.
// R7: The stamp timer is held at zero during initialization mode.
// R8: Stamp registers are read-only and writes to them are ignored.
// R9: Receive stamps read while the receive-full flag is set; transmit stamps only when empty and selected.
// R10: The stamp is shown as a high byte (bits 15..8) and a low byte (bits 7..0).
module ctp_tx_prio_stamp
    import ctp_pkg::*;
#(
    parameter int TX_BUFS = 3,
    parameter int IDX_W = 2
)
(
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic bit_tick_i,
    input wire logic tx_start_i,
    input wire logic eof_valid_i,
    input wire logic eof_is_tx_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic irq_o,
    output logic tx_request_o,
    output logic [IDX_W-1:0] tx_active_o
);

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ****************************************************************
    // State
    // ****************************************************************
    logic [1:0] ctrl;
    logic [1:0] next_ctrl;
    logic [TX_BUFS-1:0] tx_empty;
    logic [TX_BUFS-1:0] next_tx_empty;
    logic [TX_BUFS-1:0] tx_sel;
    logic [TX_BUFS-1:0] next_tx_sel;
    ctp_prio_t prio [TX_BUFS];
    ctp_prio_t next_prio [TX_BUFS];
    ctp_stamp_t tx_stamp [TX_BUFS];
    ctp_stamp_t next_tx_stamp [TX_BUFS];
    ctp_stamp_t rx_stamp;
    ctp_stamp_t next_rx_stamp;
    logic rx_full;
    logic next_rx_full;
    logic [1:0] ev_stat;
    logic [1:0] next_ev_stat;
    logic [1:0] ev_mask;
    logic [1:0] next_ev_mask;
    logic busy;
    logic next_busy;
    logic [IDX_W-1:0] next_tx_active;
    logic next_tx_request;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_irq;

    logic [15:0] timer;
    logic win_valid;
    logic [IDX_W-1:0] win_idx;
    logic [TX_BUFS*8-1:0] prio_flat;
    logic sel_valid;
    logic [IDX_W-1:0] sel_idx;
    ctp_reg_t reg_sel;
    logic setup;
    logic wr_take;

    // ****************************************************************
    // Stamp timer and buffer choice
    // ****************************************************************
    ctp_stamp_counter u_timer (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .tick_i(bit_tick_i),
        .clear_i(ctrl[`CTP_CTRL_INIT]),
        .count_o(timer)
    );

    always_comb
    begin
        for (int i = 0; i < TX_BUFS; i++)
        begin
            prio_flat[i*8 +: 8] = prio[i];
        end
    end

    ctp_prio_arbiter #(
        .BUFS(TX_BUFS),
        .IDX_W(IDX_W)
    ) u_arb (
        .request_i(~tx_empty),
        .prio_i(prio_flat),
        .win_valid_o(win_valid),
        .win_idx_o(win_idx)
    );

    // Selected buffer: lowest select bit whose buffer is empty
    always_comb
    begin
        sel_valid = 1'b0;
        sel_idx = '0;
        for (int i = TX_BUFS - 1; i >= 0; i--)
        begin
            if (tx_sel[i] && tx_empty[i])
            begin
                sel_valid = 1'b1;
                sel_idx = IDX_W'(i);
            end
        end
    end

    // ****************************************************************
    // APB decode
    // ****************************************************************
    always_comb
    begin
        case (paddr_i)
            `CTP_OFF_CTRL: reg_sel = CTP_REG_CTRL;
            `CTP_OFF_TX_FLAG: reg_sel = CTP_REG_TX_FLAG;
            `CTP_OFF_TX_SEL: reg_sel = CTP_REG_TX_SEL;
            `CTP_OFF_TX_PRIO: reg_sel = CTP_REG_TX_PRIO;
            `CTP_OFF_TX_STAMP_HI: reg_sel = CTP_REG_TX_STAMP_HI;
            `CTP_OFF_TX_STAMP_LO: reg_sel = CTP_REG_TX_STAMP_LO;
            `CTP_OFF_RX_STAMP_HI: reg_sel = CTP_REG_RX_STAMP_HI;
            `CTP_OFF_RX_STAMP_LO: reg_sel = CTP_REG_RX_STAMP_LO;
            `CTP_OFF_RX_FLAG: reg_sel = CTP_REG_RX_FLAG;
            `CTP_OFF_IRQ_STAT: reg_sel = CTP_REG_IRQ_STAT;
            `CTP_OFF_IRQ_MASK: reg_sel = CTP_REG_IRQ_MASK;
            default: reg_sel = CTP_REG_NONE;
        endcase
    end

    assign setup = psel_i & ~penable_i;
    // Error was decided in setup, so a refused write never lands
    assign wr_take = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb
    begin
        next_ctrl = ctrl;
        next_tx_empty = tx_empty;
        next_tx_sel = tx_sel;
        next_prio = prio;
        next_tx_stamp = tx_stamp;
        next_rx_stamp = rx_stamp;
        next_rx_full = rx_full;
        next_ev_stat = ev_stat;
        next_ev_mask = ev_mask;
        next_busy = busy;
        next_tx_active = tx_active_o;
        next_pready = setup;
        next_prdata = 32'h0;
        next_pslverr = 1'b0;

        // Read data and refusal are fixed in the setup cycle
        if (setup)
        begin
            case (reg_sel)
                CTP_REG_CTRL: next_prdata = {30'h0, ctrl};
                CTP_REG_TX_FLAG: next_prdata = 32'(tx_empty);
                CTP_REG_TX_SEL:
                begin
                    if (sel_valid)
                    begin
                        next_prdata = 32'h1 << sel_idx;
                    end
                end
                CTP_REG_TX_PRIO:
                begin
                    if (sel_valid)
                    begin
                        next_prdata = {24'h0, prio[sel_idx]}; // R2
                    end
                    else
                    begin
                        next_pslverr = 1'b1; // R2
                    end
                end
                CTP_REG_TX_STAMP_HI, CTP_REG_TX_STAMP_LO:
                begin
                    if (!pwrite_i && !sel_valid)
                    begin
                        next_pslverr = 1'b1; // R9 R4
                    end
                    else if (!pwrite_i && reg_sel == CTP_REG_TX_STAMP_HI)
                    begin
                        next_prdata = {24'h0, tx_stamp[sel_idx][15:8]}; // R10
                    end
                    else if (!pwrite_i)
                    begin
                        next_prdata = {24'h0, tx_stamp[sel_idx][7:0]}; // R10
                    end
                end
                CTP_REG_RX_STAMP_HI, CTP_REG_RX_STAMP_LO:
                begin
                    if (!pwrite_i && !rx_full)
                    begin
                        next_pslverr = 1'b1; // R9
                    end
                    else if (!pwrite_i && reg_sel == CTP_REG_RX_STAMP_HI)
                    begin
                        next_prdata = {24'h0, rx_stamp[15:8]}; // R10
                    end
                    else if (!pwrite_i)
                    begin
                        next_prdata = {24'h0, rx_stamp[7:0]}; // R10
                    end
                end
                CTP_REG_RX_FLAG: next_prdata = {31'h0, rx_full};
                CTP_REG_IRQ_STAT: next_prdata = {30'h0, ev_stat};
                CTP_REG_IRQ_MASK: next_prdata = {30'h0, ev_mask};
                default: next_pslverr = 1'b1;
            endcase
        end

        // Software writes come first so that hardware sets override clears
        if (wr_take)
        begin
            case (reg_sel)
                CTP_REG_CTRL: next_ctrl = pwdata_i[1:0];
                CTP_REG_TX_FLAG: next_tx_empty = tx_empty & ~pwdata_i[TX_BUFS-1:0];
                CTP_REG_TX_SEL: next_tx_sel = pwdata_i[TX_BUFS-1:0];
                CTP_REG_TX_PRIO: next_prio[sel_idx] = pwdata_i[7:0]; // R2
                CTP_REG_RX_FLAG: next_rx_full = rx_full & ~pwdata_i[0];
                CTP_REG_IRQ_STAT: next_ev_stat = ev_stat & ~pwdata_i[1:0];
                CTP_REG_IRQ_MASK: next_ev_mask = pwdata_i[1:0];
                default: next_ctrl = next_ctrl; // R8
            endcase
        end

        // Winner is frozen for the whole frame
        if (tx_start_i && win_valid && !busy && !ctrl[`CTP_CTRL_INIT])
        begin
            next_busy = 1'b1;
            next_tx_active = win_idx; // R1
        end

        if (eof_valid_i && eof_is_tx_i && busy)
        begin
            if (ctrl[`CTP_CTRL_STAMP_EN])
            begin
                next_tx_stamp[tx_active_o] = timer; // R3
            end
            next_tx_empty[tx_active_o] = 1'b1; // R4
            next_busy = 1'b0;
            next_ev_stat[`CTP_EV_TX_DONE] = 1'b1;
        end

        if (eof_valid_i && !eof_is_tx_i)
        begin
            if (ctrl[`CTP_CTRL_STAMP_EN])
            begin
                next_rx_stamp = timer; // R3
            end
            next_rx_full = 1'b1;
            next_ev_stat[`CTP_EV_RX_FULL] = 1'b1;
        end

        // Request uses the buffers as they stand now, with busy and init as they will stand next cycle
        next_tx_request = win_valid & ~next_busy & ~next_ctrl[`CTP_CTRL_INIT];
        next_irq = |(next_ev_stat & next_ev_mask);
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl <= `CTP_CTRL_RST;
            tx_empty <= '1;
            tx_sel <= '0;
            for (int i = 0; i < TX_BUFS; i++)
            begin
                prio[i] <= `CTP_PRIO_RST;
                tx_stamp[i] <= `CTP_STAMP_RST;
            end
            rx_stamp <= `CTP_STAMP_RST;
            rx_full <= 1'b0;
            ev_stat <= `CTP_EV_RST;
            ev_mask <= `CTP_EV_RST;
            busy <= 1'b0;
            tx_active_o <= '0;
            tx_request_o <= 1'b0;
            prdata_o <= 32'h0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            irq_o <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            tx_empty <= next_tx_empty;
            tx_sel <= next_tx_sel;
            prio <= next_prio;
            tx_stamp <= next_tx_stamp;
            rx_stamp <= next_rx_stamp;
            rx_full <= next_rx_full;
            ev_stat <= next_ev_stat;
            ev_mask <= next_ev_mask;
            busy <= next_busy;
            tx_active_o <= next_tx_active;
            tx_request_o <= next_tx_request;
            prdata_o <= next_prdata;
            pready_o <= next_pready;
            pslverr_o <= next_pslverr;
            irq_o <= next_irq;
        end
    end

endmodule
`default_nettype wire

// file: verification/ctp_tx_prio_stamp_asserts.sv
// Purpose: Port checks for the priority and stamp block
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound into every instance of the top module
`timescale 1ns/100ps
`default_nettype none
module ctp_tx_prio_stamp_asserts
#(
    parameter int IDX_W = 2
)
(
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic tx_start_i,
    input wire logic eof_valid_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic irq_o,
    input wire logic tx_request_o,
    input wire logic [IDX_W-1:0] tx_active_o
);
    // ************************************************************
    // Checks
    // ************************************************************
    // An irq edge needs a landed write or a frame end shortly before
    wire cause = (psel_i && penable_i && pwrite_i) || eof_valid_i;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    a_err_needs_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_err_data_zero: assert property (pslverr_o |-> prdata_o == 32'h0)
        else $error("refused read returned data");
    a_start_drops_req: assert property
        (tx_start_i && tx_request_o |=> !tx_request_o)
        else $error("request kept after start");
    a_active_on_start: assert property
        ($changed(tx_active_o) |-> $past(tx_start_i))
        else $error("active index moved without start");
    a_irq_rise_cause: assert property ($rose(irq_o) |->
        $past(cause) || $past(cause, 2) || $past(cause, 3))
        else $error("irq rose without cause");
    a_irq_fall_cause: assert property ($fell(irq_o) |->
        $past(cause) || $past(cause, 2) || $past(cause, 3))
        else $error("irq fell without write");

    c_refused: cover property (pslverr_o);
    c_start: cover property (tx_start_i && tx_request_o);
    c_irq: cover property ($rose(irq_o));
endmodule
bind ctp_tx_prio_stamp ctp_tx_prio_stamp_asserts #(.IDX_W(IDX_W)) u_chk (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .tx_start_i(tx_start_i),
    .eof_valid_i(eof_valid_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .irq_o(irq_o), .tx_request_o(tx_request_o),
    .tx_active_o(tx_active_o));
`default_nettype wire

// file: verification/ctp_can_node_model.sv
// Purpose: Frame engine and bus side seen by the block
// Assumes: Tasks are called from the bench, one at a time
// Notes: Bit ticks only run on request so stamps are exact
`timescale 1ns/100ps
`default_nettype none
module ctp_can_node_model
(
    input wire logic sys_clk_i,
    output var logic bit_tick_o,
    output var logic tx_start_o,
    output var logic eof_valid_o,
    output var logic eof_is_tx_o
);
    // ************************************************************
    // Frame events
    // ************************************************************
    initial
    begin
        bit_tick_o = 1'b0;
        tx_start_o = 1'b0;
        eof_valid_o = 1'b0;
        eof_is_tx_o = 1'b1;
    end

    task automatic ticks(input int n);
        @(posedge sys_clk_i);
        repeat (n)
        begin
            bit_tick_o <= 1'b1;
            @(posedge sys_clk_i);
        end
        bit_tick_o <= 1'b0;
    endtask

    task automatic pulse_start();
        @(posedge sys_clk_i);
        tx_start_o <= 1'b1;
        @(posedge sys_clk_i);
        tx_start_o <= 1'b0;
    endtask

    task automatic eof(input logic tx);
        @(posedge sys_clk_i);
        eof_valid_o <= 1'b1;
        eof_is_tx_o <= tx;
        @(posedge sys_clk_i);
        eof_valid_o <= 1'b0;
        // Qualifier is flipped off the pulse so it is never trusted
        eof_is_tx_o <= ~tx;
    endtask
endmodule
`default_nettype wire

// file: verification/ctp_tx_prio_stamp_tb_top.sv
// Purpose: Self-checking bench for the priority and stamp block
// Assumes: APB master tasks, node model for frame events
// Notes: Register table rows first, then frame and stamp cases
`timescale 1ns/100ps
`default_nettype none
`include "ctp_consts.svh"
`define CHK(n, x, g) begin checks_done++; if ((g) !== (x)) begin \
    error_cnt++; $display("CHECK FAILED %s exp %h got %h", n, x, g); end end
module ctp_tx_prio_stamp_tb_top;
    // ************************************************************
    // Bench
    // ************************************************************
    typedef struct packed {
        logic [7:0] a;
        logic w;
        logic [31:0] d;
        logic [31:0] x;
        logic e;
    } ctp_row_t;
    ctp_row_t rows [17] = '{
        '{8'h00, 1'b0, 32'h0, 32'h2, 1'b0}, '{8'h04, 1'b0, 32'h0, 32'h7, 1'b0},
        '{8'h0c, 1'b0, 32'h0, 32'h0, 1'b1}, '{8'h10, 1'b0, 32'h0, 32'h0, 1'b1},
        '{8'h18, 1'b0, 32'h0, 32'h0, 1'b1}, '{8'h2c, 1'b0, 32'h0, 32'h0, 1'b1},
        '{8'h01, 1'b0, 32'h0, 32'h0, 1'b1}, '{8'h08, 1'b1, 32'h2, 32'h0, 1'b0},
        '{8'h08, 1'b0, 32'h0, 32'h2, 1'b0}, '{8'h0c, 1'b1, 32'h33, 32'h0, 1'b0},
        '{8'h0c, 1'b0, 32'h0, 32'h33, 1'b0}, '{8'h10, 1'b1, 32'hff, 32'h0, 1'b0},
        '{8'h10, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'h14, 1'b0, 32'h0, 32'h0, 1'b0},
        '{8'h1c, 1'b0, 32'h0, 32'h0, 1'b1}, '{8'h20, 1'b0, 32'h0, 32'h0, 1'b0},
        '{8'h28, 1'b0, 32'h0, 32'h0, 1'b0}};
    logic [31:0] prio [3] = '{32'h5, 32'h3, 32'h3};
    logic [1:0] order [3] = '{2'h1, 2'h2, 2'h0};
    logic clk;
    logic arst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] rd;
    logic er;
    wire logic tick, start, eofv, eoftx, pready, perr, irq, txreq;
    wire logic [31:0] prdata;
    wire logic [1:0] txact;
    int error_cnt = 0;
    int checks_done = 0;

    always #2.5 clk = ~clk;

    ctp_tx_prio_stamp #(.TX_BUFS(3), .IDX_W(2)) dut (.sys_clk_i(clk),
        .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .bit_tick_i(tick), .tx_start_i(start), .eof_valid_i(eofv),
        .eof_is_tx_i(eoftx), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(perr), .irq_o(irq), .tx_request_o(txreq),
        .tx_active_o(txact));
    ctp_can_node_model node (.sys_clk_i(clk), .bit_tick_o(tick),
        .tx_start_o(start), .eof_valid_o(eofv), .eof_is_tx_o(eoftx));

    task automatic apb(input logic [7:0] a, input logic w,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = perr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x,
        input logic e);
        apb(a, 1'b0, 32'h0, rd, er);
        `CHK("slverr", e, er)
        `CHK("rdata", x, rd)
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, rd, er);
        `CHK("write slverr", 1'b0, er)
    endtask

    task automatic report_and_stop();
        if (error_cnt == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Longest path is the wrap run of some 65k ticks
    initial
    begin
        repeat (80000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end

    initial
    begin
        clk = 1'b0;
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (rows[i])
        begin
            apb(rows[i].a, rows[i].w, rows[i].d, rd, er);
            `CHK("row slverr", rows[i].e, er)
            if (!rows[i].w) `CHK("row rdata", rows[i].x, rd)
        end
        foreach (prio[i])
        begin
            wr(8'h08, 32'h1 << i);
            wr(8'h0c, prio[i]);
        end
        wr(8'h04, 32'h7);
        wr(8'h08, 32'h1);
        rd_chk(8'h0c, 32'h0, 1'b1);
        wr(8'h00, 32'h3);
        node.ticks(5);
        wr(8'h00, 32'h1);
        repeat (2) @(posedge clk);
        #1 `CHK("request", 1'b1, txreq)
        foreach (order[i])
        begin
            repeat (3) @(posedge clk);
            node.pulse_start();
            #1 `CHK("active", order[i], txact)
            node.ticks(i == 0 ? 291 : 0);
            node.eof(1'b1);
        end
        wr(8'h08, 32'h2);
        rd_chk(8'h10, 32'h01, 1'b0);
        rd_chk(8'h14, 32'h23, 1'b0);
        wr(8'h10, 32'hff);
        rd_chk(8'h10, 32'h01, 1'b0);
        node.eof(1'b0);
        rd_chk(8'h18, 32'h01, 1'b0);
        rd_chk(8'h1c, 32'h23, 1'b0);
        #1 `CHK("irq masked", 1'b0, irq)
        wr(8'h28, 32'h3);
        repeat (2) @(posedge clk);
        #1 `CHK("irq raised", 1'b1, irq)
        rd_chk(8'h24, 32'h3, 1'b0);
        wr(8'h24, 32'h3);
        repeat (2) @(posedge clk);
        #1 `CHK("irq cleared", 1'b0, irq)
        wr(8'h20, 32'h1);
        rd_chk(8'h18, 32'h0, 1'b1);
        wr(8'h00, 32'h3);
        wr(8'h00, 32'h1);
        node.ticks(65538);
        node.eof(1'b0);
        rd_chk(8'h1c, 32'h02, 1'b0);
        rd_chk(8'h24, 32'h2, 1'b0);
        @(posedge clk);
        arst_n <= 1'b0;
        #1 `CHK("irq in reset", 1'b0, irq)
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(8'h00, 32'(`CTP_CTRL_RST), 1'b0);
        rd_chk(8'h24, 32'h0, 1'b0);
        // Stamping off: flag still sets, stamp keeps its old value
        wr(8'h00, 32'h0);
        node.ticks(3);
        node.eof(1'b0);
        rd_chk(8'h20, 32'h1, 1'b0);
        rd_chk(8'h1c, 32'h00, 1'b0);
        report_and_stop();
    end
endmodule
`default_nettype wire
